// ---- shared/clt_cfg.svh ----
// constants of the contactless tag control block
`ifndef CLT_CFG_SVH
`define CLT_CFG_SVH
`define CLT_CHAR_BITS   4'ha
`define CLT_STOP_IDX    4'h9
`define CLT_MAX_LEN     4'h8
`define CLT_ADDR_SYS    8'hff
`define CLT_ADDR_CNT_A  8'h05
`define CLT_ADDR_CNT_B  8'h06
`define CLT_LOCK_LSB    16
`define CLT_ERASED      32'hffffffff
`define CLT_SYS_RST     32'hffffffff
`define CLT_CNT_A_RST   32'hfffffffe
`define CLT_CNT_B_RST   32'hffffffff
`define CLT_CRC_PRESET  16'hffff
`define CLT_CRC_POLY    16'h8408
`define CLT_CRC_RESID   16'hf0b8
`define CLT_OP_ANTI     8'h06
`define CLT_OP_ANTI_LO  4'h6
`define CLT_PAR_INIT    8'h00
`define CLT_PAR_POLL    8'h04
`define CLT_OP_SELECT   8'h0e
`define CLT_OP_COMPL    8'h0f
`define CLT_OP_READ     8'h08
`define CLT_OP_WRITE    8'h09
`define CLT_OP_UID      8'h0b
`define CLT_LEN_SHORT   4'h3
`define CLT_LEN_PARAM   4'h4
`define CLT_LEN_WRITE   4'h8
`define CLT_LEN_WORD    4'h4
`define CLT_LEN_UID     4'h8
`define CLT_LEN_ID      4'h1
`endif

// ---- shared/clt_pkg.sv ----
// types of the contactless tag control block
package clt_pkg;
    typedef enum logic [5:0] {
        CLT_OFF = 6'h01,
        CLT_RDY = 6'h02,
        CLT_INV = 6'h04,
        CLT_SEL = 6'h08,
        CLT_DES = 6'h10,
        CLT_DEA = 6'h20
    } clt_tag_st_t;
    typedef enum logic [4:0] {
        CLT_IDLE  = 5'h01,
        CLT_EXEC  = 5'h02,
        CLT_ERASE = 5'h04,
        CLT_PROG  = 5'h08,
        CLT_TX    = 5'h10
    } clt_ctl_st_t;
endpackage

// ---- verilog/clt_fifo.sv ----
// synchronous fifo with valid/ready on both sides
module clt_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output wire logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output wire logic         out_valid,
    input  wire logic         out_ready,
    output wire logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;
    // extra pointer bit tells full from empty
    assign in_ready  = (wr_q[AW] == rd_q[AW]) | (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clk_en && push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule // clt_fifo

// ---- verilog/clt_core.sv ----
// control core of the contactless tag: link receive, decode, memory, answer
`include "clt_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// R1 - blocks 7-15 user memory, erase before write
// R2 - system block 255 only clears bits
// R3 - bits 16-31 of block 255 lock blocks
// R4 - locks never reopen, locked blocks read-only
// R5 - lock changes apply after matching select
// R6 - ten-bit characters, start bit first
// R7 - reader frames: sof, data, crc, eof
// R8 - invalid frame gets no answer
// R9 - answers framed ten-bit characters plus crc
// R10 - power-up enters ready, only initiate accepted
// R11 - initiate to inventory, anticollision answered there
// R12 - matching select moves inventory to selected
// R13 - selected runs read, write, uid only
// R14 - selected: mismatch deselects, completion deactivates
// R15 - deselected returns only on matching select
// R16 - deactivated ignores everything until power loss
// R17 - eight-bit identifier, randomized on initiate
// R18 - low identifier nibble is slot number
// R19 - poll draws new slot, answers in slot 0
// R20 - slot marker answers on equal slot only
// R21 - initiate answers at once, one slot answer
// R22 - reader drives anticollision and slot separation
// R23 - frame crc preset all ones
// R24 - counters accept only strictly lower values
// R25 - locked block write starts no cycle
module clt_core #(
    parameter int          PROG_CYCLES = 8,
    parameter int          FIFO_DEPTH  = 32,
    parameter logic [15:0] LFSR_SEED   = 16'hace1,
    // arbitrary unique identifier value
    parameter logic [63:0] UID_VALUE   = 64'h0123456789abcdef
) (
    input  wire  logic        clk_sys,
    input  wire  logic        rstn,
    input  wire  logic        clk_en,
    input  wire  logic        link_clk,
    input  wire  logic        link_frame,
    input  wire  logic        link_rx,
    output logic              link_tx_q,
    output logic              link_tx_frame_q,
    output clt_pkg::clt_tag_st_t tag_state_q,
    output logic [7:0]        tag_identifier_q
);
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `CLT_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and link clock edge
    logic lclk_s1, lclk_s2, lclk_s3, frm_s1, frm_s2, frm_s3, rxd_s1, rxd_s2;
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
            {frm_s1, frm_s2, frm_s3}    <= 3'h0;
            {rxd_s1, rxd_s2}            <= 2'h3;
        end
        else if (clk_en)
        begin
            {lclk_s1, lclk_s2, lclk_s3} <= {link_clk, lclk_s1, lclk_s2};
            {frm_s1, frm_s2, frm_s3}    <= {link_frame, frm_s1, frm_s2};
            {rxd_s1, rxd_s2}            <= {link_rx, rxd_s1};
        end
    end
    wire lrise    = lclk_s2 & ~lclk_s3;
    wire frm_rise = frm_s2 & ~frm_s3;
    wire frm_fall = ~frm_s2 & frm_s3;

    ////////////////////////////////////////////////////////////////////////////
    // character receiver into the fifo
    logic [3:0] rx_cnt_q;
    logic [7:0] rx_sh_q;
    logic       rx_err_q;
    logic       eof_pend_q;
    logic       fin_ready;
    wire        bit_tick  = lrise & frm_s2 & ~eof_pend_q;
    wire        stop_tick = bit_tick & (rx_cnt_q == `CLT_STOP_IDX);
    wire        byte_push = stop_tick & rxd_s2 & ~rx_err_q;
    wire        fin_valid = byte_push | eof_pend_q;
    // marker entry carries the frame error flag in bit 0
    wire [8:0]  fin_data  = eof_pend_q ? {1'b1, 7'h00, rx_err_q} : {1'b0, rx_sh_q};

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            rx_cnt_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_err_q   <= 1'b0;
            eof_pend_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (frm_rise && !eof_pend_q)
            begin
                rx_cnt_q <= 4'h0;
                rx_err_q <= 1'b0;
            end
            else if (bit_tick)
            begin
                if ((rx_cnt_q == 4'h0 && rxd_s2) || (stop_tick && !rxd_s2)) // R6
                    rx_err_q <= 1'b1;
                // no way to stall the reader: an overrun spoils the frame
                if (stop_tick && !fin_ready)
                    rx_err_q <= 1'b1;
                if (rx_cnt_q != 4'h0 && !stop_tick)
                    rx_sh_q <= {rxd_s2, rx_sh_q[7:1]}; // R6
                rx_cnt_q <= stop_tick ? 4'h0 : rx_cnt_q + 4'h1;
            end
            if (frm_fall)
            begin
                eof_pend_q <= 1'b1;
                if (rx_cnt_q != 4'h0)
                    rx_err_q <= 1'b1;
            end
            else if (eof_pend_q && fin_ready)
                eof_pend_q <= 1'b0;
        end
    end

    clt_pkg::clt_ctl_st_t ctl_q, ctl_d;
    logic       fout_valid;
    logic [8:0] fout_data;
    wire        fout_ready = ctl_q == clt_pkg::CLT_IDLE;
    clt_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (fin_data),
        .out_valid (fout_valid),
        .out_ready (fout_ready),
        .out_data  (fout_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame buffer, crc check and command decode
    clt_pkg::clt_tag_st_t tag_d;
    logic [7:0]  buf_q [8];
    logic [3:0]  len_q;
    logic [15:0] crc_q;
    logic        ovf_q, bad_q, answered_q;
    logic [15:0] lfsr_q;
    logic [31:0] mem_q [16];
    logic [31:0] sys_q;
    logic [15:0] lock_act_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] wval_q;
    logic [15:0] prog_cnt_q;

    wire [7:0]  b0       = buf_q[0];
    wire [7:0]  b1       = buf_q[1];
    wire        frame_ok = ctl_q == clt_pkg::CLT_EXEC && !bad_q
                           && crc_q == `CLT_CRC_RESID; // R8 R23
    wire        len_sh   = len_q == `CLT_LEN_SHORT;
    wire        len_par  = len_q == `CLT_LEN_PARAM;
    wire        is_init  = len_par && b0 == `CLT_OP_ANTI && b1 == `CLT_PAR_INIT;
    wire        is_poll  = len_par && b0 == `CLT_OP_ANTI && b1 == `CLT_PAR_POLL;
    wire        is_slot  = len_sh && b0[3:0] == `CLT_OP_ANTI_LO && b0[7:4] != 4'h0;
    wire        is_sel   = len_par && b0 == `CLT_OP_SELECT;
    wire        is_comp  = len_sh && b0 == `CLT_OP_COMPL;
    wire        is_read  = len_par && b0 == `CLT_OP_READ;
    wire        is_write = len_q == `CLT_LEN_WRITE && b0 == `CLT_OP_WRITE;
    wire        is_uid   = len_sh && b0 == `CLT_OP_UID;
    wire        st_rdy   = tag_state_q == clt_pkg::CLT_RDY;
    wire        st_inv   = tag_state_q == clt_pkg::CLT_INV;
    wire        st_sel   = tag_state_q == clt_pkg::CLT_SEL;
    wire        st_des   = tag_state_q == clt_pkg::CLT_DES;
    wire        id_match = b1 == tag_identifier_q;
    wire        addr_ok  = b1[7:4] == 4'h0 || b1 == `CLT_ADDR_SYS;
    wire        go_inv   = frame_ok & is_init & (st_rdy | st_inv); // R10 R11 R21
    wire        do_poll  = frame_ok & is_poll & st_inv; // R11
    wire        poll_ans = do_poll & lfsr_q[3:0] == 4'h0; // R19
    wire        slot_hit = frame_ok & is_slot & st_inv & ~answered_q
                           & b0[7:4] == tag_identifier_q[3:0]; // R20 R18 R21
    wire        sel_hit  = frame_ok & is_sel & id_match & (st_inv | st_sel | st_des);
    wire        sel_miss = frame_ok & is_sel & ~id_match & st_sel; // R14
    wire        do_comp  = frame_ok & is_comp & st_sel; // R14
    wire        do_read  = frame_ok & is_read & st_sel & addr_ok; // R13
    wire        do_write = frame_ok & is_write & st_sel & addr_ok; // R13
    wire        do_uid   = frame_ok & is_uid & st_sel; // R13
    wire        ans_id   = go_inv | poll_ans | slot_hit | sel_hit;
    wire [7:0]  id_new   = go_inv ? lfsr_q[7:0] :
                           do_poll ? {tag_identifier_q[7:4], lfsr_q[3:0]} :
                           tag_identifier_q; // R17 R19
    wire [31:0] rd_word  = b1 == `CLT_ADDR_SYS ? sys_q : mem_q[b1[3:0]];
    // data bytes follow opcode and address, lsb first
    wire [31:0] wval     = {buf_q[5], buf_q[4], buf_q[3], buf_q[2]};
    wire        wr_sys   = b1 == `CLT_ADDR_SYS;
    wire        wr_cnt   = b1 == `CLT_ADDR_CNT_A || b1 == `CLT_ADDR_CNT_B;
    wire        locked   = !wr_sys && !lock_act_q[b1[3:0]]; // R3 R4
    wire        val_ok   = wr_sys ? sys_q != 32'h0 : // R2
                           wr_cnt ? wval < mem_q[b1[3:0]] : 1'b1; // R24
    wire        wr_start = do_write & ~locked & val_ok; // R25
    wire [3:0]  resp_len = do_uid ? `CLT_LEN_UID : do_read ? `CLT_LEN_WORD :
                           ans_id ? `CLT_LEN_ID : 4'h0;
    wire        prog_end = prog_cnt_q == 16'(PROG_CYCLES - 1);
    logic [7:0] resp_d [8];
    for (genvar i = 0; i < 8; i++)
    begin : g_resp
        if (i < 4)
        begin : g_lo
            assign resp_d[i] = do_uid ? UID_VALUE[8*i +: 8] : do_read ? rd_word[8*i +: 8] :
                               (i == 0) ? id_new : 8'h00;
        end
        else
        begin : g_hi
            assign resp_d[i] = UID_VALUE[8*i +: 8];
        end
    end

    assign tag_d = tag_state_q == clt_pkg::CLT_OFF ? clt_pkg::CLT_RDY : // R10
                   go_inv   ? clt_pkg::CLT_INV : // R11
                   sel_hit  ? clt_pkg::CLT_SEL : // R12 R15
                   sel_miss ? clt_pkg::CLT_DES :
                   do_comp  ? clt_pkg::CLT_DEA : tag_state_q; // R16

    ////////////////////////////////////////////////////////////////////////////
    // answer transmitter
    logic [7:0]  resp_q [8];
    logic [3:0]  resp_len_q, tx_bit_q, tx_idx_q;
    logic [7:0]  tx_byte_q;
    logic [15:0] tx_crc_q;
    wire [3:0]   nxt_idx  = tx_idx_q + 4'h1;
    wire [3:0]   tx_last  = resp_len_q + 4'h1;
    wire         tx_char  = ctl_q == clt_pkg::CLT_TX && lrise;
    wire         char_end = tx_bit_q == `CLT_CHAR_BITS;
    wire         tx_done  = tx_char && char_end && tx_idx_q == tx_last;
    wire [7:0]   nxt_byte = nxt_idx < resp_len_q ? resp_q[nxt_idx[2:0]] :
                            nxt_idx == resp_len_q ? ~tx_crc_q[7:0] : ~tx_crc_q[15:8]; // R9
    wire         bit_val  = tx_bit_q == 4'h0 ? 1'b0 : tx_bit_q == `CLT_STOP_IDX ? 1'b1 :
                            tx_byte_q[3'(tx_bit_q - 4'h1)]; // R9

    always_comb
    begin
        ctl_d = ctl_q;
        case (ctl_q)
            clt_pkg::CLT_IDLE:  if (fout_valid && fout_data[8]) ctl_d = clt_pkg::CLT_EXEC;
            clt_pkg::CLT_EXEC:  ctl_d = wr_start ? (wr_sys ? clt_pkg::CLT_PROG :
                                        clt_pkg::CLT_ERASE) : // R1 R2
                                        resp_len != 4'h0 ? clt_pkg::CLT_TX :
                                        clt_pkg::CLT_IDLE;
            clt_pkg::CLT_ERASE: if (prog_end) ctl_d = clt_pkg::CLT_PROG;
            clt_pkg::CLT_PROG:  if (prog_end) ctl_d = clt_pkg::CLT_IDLE;
            clt_pkg::CLT_TX:    if (tx_done) ctl_d = clt_pkg::CLT_IDLE;
            default:            ctl_d = clt_pkg::CLT_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state, buffer and lock registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            ctl_q            <= clt_pkg::CLT_IDLE;
            tag_state_q      <= clt_pkg::CLT_OFF;
            tag_identifier_q <= 8'h00;
            lfsr_q           <= LFSR_SEED;
            len_q            <= 4'h0;
            crc_q            <= `CLT_CRC_PRESET;
            {ovf_q, bad_q, answered_q} <= 3'h0;
            for (int i = 0; i < 8; i++)
                buf_q[i] <= 8'h00;
        end
        else if (clk_en)
        begin
            ctl_q  <= ctl_d;
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
            if (tag_state_q == clt_pkg::CLT_OFF)
                tag_identifier_q <= lfsr_q[7:0]; // R10 R17
            tag_state_q <= tag_d;
            if (fout_valid && ctl_q == clt_pkg::CLT_IDLE)
            begin
                if (fout_data[8])
                    bad_q <= fout_data[0] | ovf_q;
                else if (len_q == `CLT_MAX_LEN)
                    ovf_q <= 1'b1;
                else
                begin
                    buf_q[len_q[2:0]] <= fout_data[7:0];
                    len_q <= len_q + 4'h1;
                    crc_q <= crc_upd(crc_q, fout_data[7:0]); // R23
                end
            end
            if (ctl_q == clt_pkg::CLT_EXEC)
            begin
                tag_identifier_q <= id_new;
                len_q <= 4'h0;
                crc_q <= `CLT_CRC_PRESET;
                ovf_q <= 1'b0;
                if (go_inv || do_poll)
                    answered_q <= 1'b0;
                if (poll_ans || slot_hit)
                    answered_q <= 1'b1; // R21
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 16; i++)
                mem_q[i] <= `CLT_ERASED;
            mem_q[5]   <= `CLT_CNT_A_RST;
            mem_q[6]   <= `CLT_CNT_B_RST;
            sys_q      <= `CLT_SYS_RST;
            lock_act_q <= 16'(`CLT_SYS_RST >> `CLT_LOCK_LSB);
            wr_addr_q  <= 8'h00;
            wval_q     <= 32'h0;
            prog_cnt_q <= 16'h0;
        end
        else if (clk_en)
        begin
            if (sel_hit)
                lock_act_q <= sys_q[31:`CLT_LOCK_LSB]; // R5
            if (ctl_q == clt_pkg::CLT_EXEC)
            begin
                wr_addr_q  <= b1;
                wval_q     <= wval;
                prog_cnt_q <= 16'h0;
            end
            else if (ctl_q == clt_pkg::CLT_ERASE || ctl_q == clt_pkg::CLT_PROG)
                prog_cnt_q <= prog_end ? 16'h0 : prog_cnt_q + 16'h1;
            if (ctl_q == clt_pkg::CLT_ERASE && prog_end)
                mem_q[wr_addr_q[3:0]] <= `CLT_ERASED; // R1
            if (ctl_q == clt_pkg::CLT_PROG && prog_end)
            begin
                if (wr_addr_q == `CLT_ADDR_SYS)
                    sys_q <= sys_q & wval_q; // R2 R4
                else
                    mem_q[wr_addr_q[3:0]] <= wval_q; // R1
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            link_tx_q       <= 1'b1;
            link_tx_frame_q <= 1'b0;
            resp_len_q      <= 4'h0;
            {tx_bit_q, tx_idx_q, tx_byte_q} <= 16'h0;
            tx_crc_q        <= `CLT_CRC_PRESET;
            for (int i = 0; i < 8; i++)
                resp_q[i] <= 8'h00;
        end
        else if (clk_en)
        begin
            if (ctl_q == clt_pkg::CLT_EXEC && ctl_d == clt_pkg::CLT_TX)
            begin
                resp_q          <= resp_d;
                resp_len_q      <= resp_len;
                link_tx_frame_q <= 1'b1; // R9
                tx_idx_q        <= 4'h0;
                tx_bit_q        <= 4'h0;
                tx_byte_q       <= resp_d[0];
                tx_crc_q        <= crc_upd(`CLT_CRC_PRESET, resp_d[0]); // R23
            end
            else if (tx_done)
            begin
                link_tx_frame_q <= 1'b0;
                link_tx_q       <= 1'b1;
            end
            else if (tx_char && char_end)
            begin
                tx_idx_q  <= nxt_idx;
                tx_byte_q <= nxt_byte;
                tx_bit_q  <= 4'h0;
                if (nxt_idx < resp_len_q)
                    tx_crc_q <= crc_upd(tx_crc_q, nxt_byte);
            end
            else if (tx_char)
            begin
                link_tx_q <= bit_val; // R9
                tx_bit_q  <= tx_bit_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    locked_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R25
        do_write && locked |=> ctl_q != clt_pkg::CLT_ERASE && ctl_q != clt_pkg::CLT_PROG)
        else $error("locked block started a write cycle");
    sys_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
        (sys_q & ~$past(sys_q)) == 32'h0)
        else $error("system block bit went from zero to one");
    lock_load_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
        $changed(lock_act_q) |-> $past(sel_hit))
        else $error("lock protection changed without select");
    ready_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
        st_rdy && clk_en |=> tag_state_q inside {clt_pkg::CLT_RDY, clt_pkg::CLT_INV})
        else $error("ready left by something other than initiate");
    deact_stay_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R16
        tag_state_q == clt_pkg::CLT_DEA |=> tag_state_q == clt_pkg::CLT_DEA)
        else $error("deactivated state left");
    bad_silent_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
        ctl_q == clt_pkg::CLT_EXEC && !frame_ok |=> ctl_q != clt_pkg::CLT_TX)
        else $error("answer to invalid frame");
    erase_first_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
        $rose(ctl_q == clt_pkg::CLT_PROG) && wr_addr_q != `CLT_ADDR_SYS
        |-> $past(ctl_q == clt_pkg::CLT_ERASE))
        else $error("user block programmed without erase");
    counter_down_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R24
        $rose(ctl_q == clt_pkg::CLT_ERASE)
        && wr_addr_q inside {`CLT_ADDR_CNT_A, `CLT_ADDR_CNT_B}
        |-> wval_q < mem_q[wr_addr_q[3:0]])
        else $error("counter write not lower");
    tx_frame_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
        link_tx_frame_q |-> ctl_q == clt_pkg::CLT_TX)
        else $error("answer frame outside transmit");
    lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
        (lock_act_q & ~$past(lock_act_q)) == 16'h0)
        else $error("write lock reopened");
    sel_enter_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tag_state_q == clt_pkg::CLT_SEL));
    poll_ans_c: cover property (@(posedge clk_sys) disable iff (!rstn) poll_ans);
    write_done_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        ctl_q == clt_pkg::CLT_PROG && prog_end);
    tx_done_c: cover property (@(posedge clk_sys) disable iff (!rstn) tx_done);
endmodule // clt_core

// ---- test/clt_rdr_model.sv ----
// reader model: serial request frames out, answer frames captured
module clt_rdr_model (
    input  wire logic clk_sys,
    output logic      link_clk,
    output logic      link_frame,
    output logic      link_rx,
    input  wire logic link_tx_q,
    input  wire logic link_tx_frame_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung;
    logic ferr;
    initial
    begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        link_rx = 1'b1;
    end
    function automatic logic [15:0] crc_reg(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i])
            for (int k = 0; k < 8; k++)
                c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 16'h8408 : 16'h0000);
        return c;
    endfunction
    // link clock moves during request frames and answer capture: 8 system cycles per half bit
    task automatic half(input logic c);
        repeat (8) @(posedge clk_sys);
        link_clk <= c;
    endtask
    task automatic put_bit(input logic b);
        half(1'b0);
        link_rx <= b;
        half(1'b1);
    endtask
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = ~crc_reg(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        @(posedge clk_sys);
        link_frame <= 1'b1;
        foreach (q[i])
        begin
            put_bit(1'b0);
            for (int k = 0; k < 8; k++)
                put_bit(q[i][k]);
            put_bit(1'b1);
        end
        half(1'b0);
        link_frame <= 1'b0;
        // released line must not keep showing the last bit
        link_rx <= ~link_rx;
    endtask
    task automatic recv(output logic [7:0] q[$]);
        logic [10:0] s;
        int          n;
        q = {};
        n = 0;
        ferr = 1'b0;
        for (int i = 0; i < 400 && !link_tx_frame_q; i++)
            @(posedge clk_sys);
        while (link_tx_frame_q && n < 1200)
        begin
            half(1'b1);
            half(1'b0);
            s = {link_tx_q, s[10:1]};
            n++;
            if (n % 11 == 0)
            begin
                q.push_back(s[8:1]);
                ferr = ferr | s[0] | ~s[9];
            end
        end
        hung = n >= 1200;
    endtask
endmodule // clt_rdr_model

// ---- test/tb_top.sv ----
// testbench: reader frames driven against the tag control core
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys, rstn, clk_en;
    logic                 link_clk, link_frame, link_rx, link_tx_q, link_tx_frame_q;
    clt_pkg::clt_tag_st_t tag_state_q;
    logic [7:0]           tag_identifier_q, an[$];
    logic [3:0]           s;
    int                   n_fail, n_tests;
    clt_core DUT (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .link_clk(link_clk),
        .link_frame(link_frame), .link_rx(link_rx), .link_tx_q(link_tx_q),
        .link_tx_frame_q(link_tx_frame_q), .tag_state_q(tag_state_q),
        .tag_identifier_q(tag_identifier_q));
    clt_rdr_model rdr (.clk_sys(clk_sys), .link_clk(link_clk), .link_frame(link_frame),
        .link_rx(link_rx), .link_tx_q(link_tx_q), .link_tx_frame_q(link_tx_frame_q));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic st(input clt_pkg::clt_tag_st_t e);
        chk("state", 32'(e), 32'(tag_state_q));
    endtask
    // n < 0 leaves the answer length to the caller
    task automatic xf(input logic [7:0] q[$], input int n, input logic bad = 1'b0);
        rdr.send(q, bad);
        rdr.recv(an);
        if (rdr.hung)
        begin
            n_fail++;
            end_sim;
        end
        if (n >= 0)
            chk("len", n, an.size() == 0 ? 0 : an.size() - 2);
        if (an.size() > 0)
            chk("crc", 32'h0000f0b8, {16'h0000, rdr.crc_reg(an)});
        chk("frame", 32'h0, {31'h0, rdr.ferr});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        xf('{8'h09, a, w[7:0], w[15:8], w[23:16], w[31:24]}, 0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xf('{8'h08, a}, 4);
        chk("word", e, {an[3], an[2], an[1], an[0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        rstn = 1'b0;
        clk_en = 1'b1;
        n_fail = 0;
        n_tests = 0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        st(clt_pkg::CLT_RDY);
        xf('{8'h06, 8'h04}, 0);
        xf('{8'h06, 8'h00}, 1);
        chk("id", {24'h0, tag_identifier_q}, {24'h0, an[0]});
        st(clt_pkg::CLT_INV);
        xf('{8'h06, 8'h00}, 0, 1'b1);
        xf('{8'h0a}, 0);
        xf('{8'h06, 8'h04}, -1);
        s = tag_identifier_q[3:0];
        chk("poll", {31'h0, s == 4'h0}, {31'h0, an.size() > 0});
        xf('{{(s == 4'hf) ? 4'h1 : s + 4'h1, 4'h6}}, 0);
        if (s != 4'h0)
        begin
            xf('{{s, 4'h6}}, 1);
            xf('{{s, 4'h6}}, 0);
        end
        xf('{8'h0e, tag_identifier_q ^ 8'h01}, 0);
        st(clt_pkg::CLT_INV);
        xf('{8'h0e, tag_identifier_q}, 1);
        st(clt_pkg::CLT_SEL);
        xf('{8'h06, 8'h04}, 0);
        wr(8'h07, 32'h12345678);
        rd(8'h07, 32'h12345678);
        rd(8'h05, 32'hfffffffe);
        wr(8'h05, 32'hffffffff);
        rd(8'h05, 32'hfffffffe);
        wr(8'h05, 32'h00000010);
        rd(8'h05, 32'h00000010);
        wr(8'hff, 32'hff7fffff);
        rd(8'hff, 32'hff7fffff);
        wr(8'h07, 32'ha5a5a5a5);
        rd(8'h07, 32'ha5a5a5a5);
        xf('{8'h0e, tag_identifier_q}, 1);
        wr(8'h07, 32'h00000000);
        rd(8'h07, 32'ha5a5a5a5);
        wr(8'hff, 32'hffffffff);
        rd(8'hff, 32'hff7fffff);
        xf('{8'h0b}, 8);
        chk("uid", DUT.UID_VALUE[31:0], {an[3], an[2], an[1], an[0]});
        xf('{8'h0e, tag_identifier_q ^ 8'h80}, 0);
        st(clt_pkg::CLT_DES);
        xf('{8'h08, 8'h07}, 0);
        xf('{8'h0e, tag_identifier_q}, 1);
        st(clt_pkg::CLT_SEL);
        xf('{8'h0f}, 0);
        st(clt_pkg::CLT_DEA);
        xf('{8'h0e, tag_identifier_q}, 0);
        st(clt_pkg::CLT_DEA);
        end_sim;
    end
endmodule // tb_top
